// ===== verilog/irt_pkg.sv
// Constants for the ISA I/O recovery timer and clock divider
`default_nettype none
package irt_pkg;
  // ==========================================================
  // Configuration register
  localparam logic [7:0] IRT_CFG_ADDR = 8'h40;
  localparam logic [7:0] IRT_CFG_RESET = 8'h4d;
  localparam int IRT_DIV_SEL_BIT = 7;
  localparam int IRT_EN8_BIT = 6;
  localparam int IRT_F8_MSB = 5;
  localparam int IRT_F8_LSB = 3;
  localparam int IRT_EN16_BIT = 2;
  localparam int IRT_F16_MSB = 1;
  localparam int IRT_F16_LSB = 0;
  // ==========================================================
  // Divider
  localparam logic [2:0] IRT_DIV_FAST = 3'h3;
  localparam logic [2:0] IRT_DIV_SLOW = 3'h4;
  localparam logic [2:0] IRT_HIGH_CNT = 3'h2;
  // ==========================================================
  // Recovery figures, in ISA clocks or half ISA clocks
  localparam logic [7:0] IRT_MIN_HALF_CLKS = 8'h07;
  localparam logic [3:0] IRT_ZERO8_EXTRA = 4'h8;
  localparam logic [3:0] IRT_ZERO16_EXTRA = 4'h4;
  localparam int IRT_CNT_W = 8;
endpackage
`default_nettype wire

// ===== verilog/irt_clkdiv.sv
// ISA bus clock divider from the PCI clock
`timescale 1ns/1ns
`default_nettype none
module irt_clkdiv (
  input wire logic clk_i,              // PCI clock
  input wire logic rstn_i,             // Async reset, active low
  input wire logic div_sel_i,          // 1: divide by 3, 0: by 4
  output logic [2:0] div_o,            // Current divisor
  output logic isa_bus_clock_o         // Derived ISA bus clock
);
  import irt_pkg::*;

  typedef struct packed {
    logic [2:0] cnt;
    logic clk;
  } irt_div_st_t;

  irt_div_st_t st;
  irt_div_st_t next_st;

  assign div_o = div_sel_i ? IRT_DIV_FAST : IRT_DIV_SLOW; // [RQ4]
  assign isa_bus_clock_o = st.clk;

  // ==========================================================
  // Counter; a divisor change applies at once to the count in progress
  always_comb begin
    next_st = st;
    if (st.cnt >= div_o - 3'h1) begin // [RQ4]
      next_st.cnt = 3'h0;
    end else begin
      next_st.cnt = st.cnt + 3'h1;
    end
    next_st.clk = next_st.cnt < IRT_HIGH_CNT;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Checks
  AST_DIV3: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RQ4]
    (div_sel_i && st.cnt == 3'h0) ##1 div_sel_i ##1 div_sel_i
      |=> st.cnt == 3'h0)
    else $error("divide by 3 period wrong");
  AST_DIV4: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RQ4]
    (!div_sel_i && st.cnt == 3'h0) ##1 !div_sel_i[*3]
      |=> st.cnt == 3'h0)
    else $error("divide by 4 period wrong");
endmodule
`default_nettype wire

// ===== verilog/irt_timer.sv
// ISA I/O recovery timer with configuration register, top level
`timescale 1ns/1ns
`default_nettype none
// Function
// RQ1 - At least 3.5 ISA clocks between back-to-back PCI I/O cycles, always; cmd_ok_o waives it while cyc_sub_i is set.
// RQ2 - Gap counts from command strobe deassert to next command assert.
// RQ3 - Sub-cycles of one split PCI access get no extra recovery.
// RQ4 - ISA clock is PCI clock divided by 3 if bit 7 set, else 4.
// RQ5 - Bit 6 enables 8-bit field; cleared means default recovery only.
// RQ6 - 8-bit field codes 1 to 7 add that many ISA clocks.
// RQ7 - 16-bit field applies only while bit 2 is set.
// RQ8 - 16-bit codes 1 to 3 add that many clocks; code 0 adds 4.
// RQ9 - Recovery only for PCI-initiated I/O cycles; added to the gap.
// RQ10 - 8-bit code 0 while enabled adds eight ISA clocks.
module irt_timer (
  input wire logic clk_i,              // PCI clock, 50 MHz
  input wire logic rstn_i,             // Async reset, active low
  input wire logic cfg_wr_i,           // Config write strobe
  input wire logic [7:0] cfg_addr_i,   // Config byte offset
  input wire logic [7:0] cfg_wdata_i,  // Config write data
  output logic [7:0] cfg_rdata_o,      // Config read data, registered
  input wire logic cyc_pci_i,          // Current I/O cycle is PCI-initiated
  input wire logic cyc_is16_i,         // Current I/O cycle is 16-bit
  input wire logic cyc_sub_i,          // Current is a later split sub-cycle
  input wire logic cmd_active_i,       // I/O command strobe asserted
  output logic cmd_ok_o,               // Next command strobe may assert
  output logic rec_busy_o,             // Recovery gap still running
  output logic isa_bus_clock_o         // Derived ISA bus clock
);
  import irt_pkg::*;

  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] rdata;
    logic cmd_prev;
    logic last16;
    logic last_pci;
    logic [IRT_CNT_W-1:0] cnt;
    // Monitor only: PCI clocks of recovery seen since strobe release
    logic [IRT_CNT_W-1:0] gap_len;
  } irt_st_t;

  irt_st_t st;
  irt_st_t next_st;
  logic [2:0] div;
  logic fall_now;
  logic [3:0] extra;
  logic [7:0] base;
  logic [7:0] load;

  irt_clkdiv u_div (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .div_sel_i(st.cfg[IRT_DIV_SEL_BIT]),
    .div_o(div),
    .isa_bus_clock_o(isa_bus_clock_o)
  );

  // Deasserting edge of the command strobe starts the gap
  assign fall_now = st.cmd_prev & ~cmd_active_i; // [RQ2]

  // ==========================================================
  // Recovery length in PCI clocks
  always_comb begin
    // 3.5 ISA clocks rounded up to whole PCI clocks
    base = (IRT_MIN_HALF_CLKS * {5'h0, div} + 8'h01) >> 1; // [RQ1]
    extra = 4'h0;
    if (st.last16) begin
      if (st.cfg[IRT_EN16_BIT]) begin // [RQ7]
        extra = (st.cfg[IRT_F16_MSB:IRT_F16_LSB] == 2'h0) ?
          IRT_ZERO16_EXTRA : {2'h0, st.cfg[IRT_F16_MSB:IRT_F16_LSB]}; // [RQ8]
      end
    end else if (st.cfg[IRT_EN8_BIT]) begin // [RQ5]
      extra = (st.cfg[IRT_F8_MSB:IRT_F8_LSB] == 3'h0) ?
        IRT_ZERO8_EXTRA : {1'h0, st.cfg[IRT_F8_MSB:IRT_F8_LSB]}; // [RQ6] [RQ10]
    end
    // Rounding up costs at most half a PCI clock of throughput but
    // never lets a gap fall short of the floor, whatever the divisor.
    // Extra clocks are added on top of the fixed minimum
    load = base + {4'h0, extra} * {5'h0, div} - 8'h01; // [RQ9]
  end

  // ==========================================================
  // State update
  always_comb begin
    next_st = st;
    if (cfg_wr_i && cfg_addr_i == IRT_CFG_ADDR) begin
      next_st.cfg = cfg_wdata_i;
    end
    next_st.rdata = (cfg_addr_i == IRT_CFG_ADDR) ? st.cfg : 8'h00;
    next_st.cmd_prev = cmd_active_i;
    if (cmd_active_i) begin
      next_st.last16 = cyc_is16_i;
      next_st.last_pci = cyc_pci_i;
      next_st.cnt = '0;
    end else if (fall_now && st.last_pci) begin
      next_st.cnt = load; // [RQ2] [RQ9]
    end else if (st.cnt != '0) begin
      next_st.cnt = st.cnt - 8'h01;
    end
    // Gap length for the checks below; saturates rather than wraps
    // so a stuck busy flag cannot look like a short gap
    if (cmd_active_i) begin
      next_st.gap_len = '0;
    end else if (rec_busy_o && st.gap_len != '1) begin
      next_st.gap_len = st.gap_len + 8'h01;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= '0;
      st.cfg <= IRT_CFG_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign cfg_rdata_o = st.rdata;
  assign rec_busy_o = (st.cnt != '0) | (fall_now & st.last_pci);
  // Sub-cycles and non-PCI cycles bypass the gap; this trusts the
  // cycle engine to flag only genuine split sub-cycles
  assign cmd_ok_o = ~cyc_pci_i | cyc_sub_i | ~rec_busy_o; // [RQ3] [RQ9]

  // ==========================================================
  // Checks
  sequence s_pci_end;
    fall_now && st.last_pci;
  endsequence

  sequence s_end8;
    s_pci_end and !st.last16;
  endsequence

  sequence s_end16;
    s_pci_end and st.last16;
  endsequence

  AST_MIN_GAP: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RQ1]
    s_pci_end ##1 !cmd_active_i |-> rec_busy_o[*8])
    else $error("recovery shorter than minimum");
  AST_BLOCK_AT_END: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RQ2]
    s_pci_end and (cyc_pci_i && !cyc_sub_i) |-> !cmd_ok_o)
    else $error("command allowed at strobe deassert");
  AST_SUB_PASS: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RQ3]
    cyc_sub_i |-> cmd_ok_o)
    else $error("sub-cycle delayed");
  AST_NONPCI: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RQ9]
    !cyc_pci_i |-> cmd_ok_o)
    else $error("non-PCI cycle delayed");
  AST_EN8_OFF: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RQ5]
    s_end8 and !st.cfg[IRT_EN8_BIT] |=> st.cnt == $past(base) - 8'h01)
    else $error("8-bit recovery not default when disabled");
  AST_CODE8: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RQ6]
    s_end8 and st.cfg[IRT_EN8_BIT] && st.cfg[IRT_F8_MSB:IRT_F8_LSB] != 3'h0
    |=> st.cnt == $past(base) - 8'h01 +
      {5'h0, $past(st.cfg[IRT_F8_MSB:IRT_F8_LSB])} * {5'h0, $past(div)})
    else $error("8-bit extra recovery wrong");
  AST_CODE8_ZERO: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RQ10]
    s_end8 and st.cfg[IRT_EN8_BIT] && st.cfg[IRT_F8_MSB:IRT_F8_LSB] == 3'h0
    |=> st.cnt == $past(base) - 8'h01 + 8'h08 * {5'h0, $past(div)})
    else $error("8-bit code zero not eight clocks");
  AST_EN16_OFF: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RQ7]
    s_end16 and !st.cfg[IRT_EN16_BIT] |=> st.cnt == $past(base) - 8'h01)
    else $error("16-bit recovery not default when disabled");
  AST_CODE16: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RQ8]
    s_end16 and st.cfg[IRT_EN16_BIT] |=> st.cnt == $past(base) - 8'h01 +
      ($past(st.cfg[IRT_F16_MSB:IRT_F16_LSB]) == 2'h0 ? 8'h04 :
       {6'h0, $past(st.cfg[IRT_F16_MSB:IRT_F16_LSB])}) * {5'h0, $past(div)})
    else $error("16-bit extra recovery wrong");
  AST_BASE: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RQ1]
    base == (st.cfg[IRT_DIV_SEL_BIT] ? 8'h0b : 8'h0e))
    else $error("minimum recovery count wrong");

  // ==========================================================
  // Further checks; AST_GAP_LEN times the busy flag itself, so a fault in
  // the load arithmetic cannot hide behind the counter
  AST_GAP_LEN: assert property ( // [RQ1]
    @(posedge clk_i) disable iff (!rstn_i)
    $fell(rec_busy_o) && !cmd_active_i
    |-> {st.gap_len, 1'b0} >= {1'b0, IRT_MIN_HALF_CLKS} * {6'h0, div})
    else $error("recovery gap shorter than minimum");

  AST_BUSY_BLOCKS: assert property ( // [RQ1]
    @(posedge clk_i) disable iff (!rstn_i)
    rec_busy_o && cyc_pci_i && !cyc_sub_i |-> !cmd_ok_o)
    else $error("command allowed during recovery");

  AST_COUNT_DOWN: assert property ( // [RQ2]
    @(posedge clk_i) disable iff (!rstn_i)
    st.cnt != '0 && !cmd_active_i && !fall_now
    |=> st.cnt == $past(st.cnt) - 8'h01)
    else $error("recovery count not stepping down");

  AST_NO_LOAD: assert property ( // [RQ9]
    @(posedge clk_i) disable iff (!rstn_i)
    fall_now && !st.last_pci && st.cnt == '0 |=> st.cnt == '0)
    else $error("non-PCI cycle loaded recovery");

  AST_STROBE_CLEARS: assert property ( // [RQ3]
    @(posedge clk_i) disable iff (!rstn_i)
    cmd_active_i |=> st.cnt == '0)
    else $error("recovery left running under a strobe");

  AST_TYPE_LATCH: assert property ( // [RQ7]
    @(posedge clk_i) disable iff (!rstn_i)
    cmd_active_i |=> st.last16 == $past(cyc_is16_i) &&
      st.last_pci == $past(cyc_pci_i))
    else $error("cycle type not latched during strobe");

  AST_CFG_HOLD: assert property ( // [RQ4]
    @(posedge clk_i) disable iff (!rstn_i)
    !(cfg_wr_i && cfg_addr_i == IRT_CFG_ADDR)
    |=> st.cfg == $past(st.cfg))
    else $error("configuration changed without a write");
endmodule
`default_nettype wire

// ===== tb/irt_io_model.sv
// Behavioural ISA cycle engine: runs one strobe, then times the gap
`timescale 1ns/1ns
`default_nettype none
module irt_io_model (
  input wire logic clk_i,       // PCI clock
  input wire logic rstn_i,      // Async reset, active low
  input wire logic req_i,       // Pulse: run one I/O cycle
  input wire logic cmd_ok_i,    // Strobe may assert
  input wire logic rec_busy_i,  // Recovery gap running
  output logic cmd_active_o,    // Command strobe
  output logic [7:0] gap_o,     // Busy clocks seen after strobe drop
  output logic done_o           // Pulse: gap measured
);
  logic pend;
  logic meas;
  logic [1:0] len;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {pend, meas, len, cmd_active_o, gap_o, done_o} <= '0;
    end else begin
      done_o <= 1'b0;
      if (req_i) pend <= 1'b1;
      if (cmd_active_o) begin
        len <= len - 2'h1;
        if (len == 2'h1) {cmd_active_o, meas, gap_o} <= {2'b01, 8'h00};
      end else if (meas) begin
        if (rec_busy_i) gap_o <= gap_o + 8'h01;
        else {meas, done_o} <= 2'b01;
      end else if ((pend || req_i) && cmd_ok_i) begin // Honours gap
        {pend, cmd_active_o, len} <= 4'b0111;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/irt_timer_tb.sv
// Self-checking bench for the ISA I/O recovery timer
`timescale 1ns/1ns
`default_nettype none
module irt_timer_tb;
  import irt_pkg::*;
  logic clk_i = 0, rstn_i = 0, cfg_wr_i = 0, cyc_pci_i = 1, cyc_is16_i = 0;
  logic cyc_sub_i = 0, req = 0, cmd_active, cmd_ok_o, rec_busy_o, done;
  logic isa_bus_clock_o;
  logic [7:0] cfg_addr_i = 8'h00, cfg_wdata_i = 8'h00, cfg_rdata_o, gap;
  int n_fail = 0, compares = 0, cyc = 0;
  always #10 clk_i = ~clk_i;
  irt_timer irt_timer_inst (.clk_i(clk_i), .rstn_i(rstn_i),
    .cfg_wr_i(cfg_wr_i), .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i),
    .cfg_rdata_o(cfg_rdata_o), .cyc_pci_i(cyc_pci_i), .cyc_is16_i(cyc_is16_i),
    .cyc_sub_i(cyc_sub_i), .cmd_active_i(cmd_active), .cmd_ok_o(cmd_ok_o),
    .rec_busy_o(rec_busy_o), .isa_bus_clock_o(isa_bus_clock_o));
  irt_io_model irt_io_model_inst (.clk_i(clk_i), .rstn_i(rstn_i),
    .req_i(req), .cmd_ok_i(cmd_ok_o), .rec_busy_i(rec_busy_o),
    .cmd_active_o(cmd_active), .gap_o(gap), .done_o(done));
  // ==========================================================
  // Shared tasks
  task stop_test;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task cmp(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i) {cfg_wr_i, cfg_addr_i, cfg_wdata_i} <= {1'b1, a, d};
    @(posedge clk_i) cfg_wr_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i) cfg_addr_i <= a;
    repeat (2) @(posedge clk_i);
    #1 cmp(cfg_rdata_o, exp);
  endtask
  // Gap in PCI clocks: 3.5 ISA clocks rounded up, plus extra ISA clocks
  function automatic logic [7:0] expn(logic d3, logic [7:0] x);
    return d3 ? 8'h0b + x * 8'h03 : 8'h0e + x * 8'h04;
  endfunction
  task run(input logic [7:0] c, input logic p, input logic w,
           input logic [7:0] n);
    wr(IRT_CFG_ADDR, c);
    {cyc_pci_i, cyc_is16_i, req} <= {p, w, 1'b1};
    @(posedge clk_i) req <= 1'b0;
    for (int i = 0; i < 100 && done !== 1'b1; i++) @(posedge clk_i) #1;
    cmp({7'h00, done}, 8'h01);
    cmp(gap, n);
  endtask
  // ==========================================================
  // Scenarios
  task t_reg;
    rd(IRT_CFG_ADDR, IRT_CFG_RESET);
    wr(8'h41, 8'hff);
    rd(8'h41, 8'h00);
    rd(IRT_CFG_ADDR, IRT_CFG_RESET);
    wr(IRT_CFG_ADDR, 8'hb2);
    rd(IRT_CFG_ADDR, 8'hb2);
  endtask
  // A 12-clock window holds whole periods of both divisors
  task t_div(input logic [7:0] c, input logic [7:0] n);
    logic [7:0] h;
    h = 8'h00;
    wr(IRT_CFG_ADDR, c);
    repeat (8) @(posedge clk_i);
    repeat (12) @(posedge clk_i) #1 h += {7'h00, isa_bus_clock_o};
    cmp(h, n);
  endtask
  task t_sub;
    wr(IRT_CFG_ADDR, IRT_CFG_RESET);
    {cyc_pci_i, req} <= 2'b11;
    @(posedge clk_i) req <= 1'b0;
    for (int i = 0; i < 20 && rec_busy_o !== 1'b1; i++) @(posedge clk_i) #1;
    @(posedge clk_i) cyc_sub_i <= 1'b1;
    #1 cmp(cmd_ok_o, 8'h01);
    @(posedge clk_i) cyc_sub_i <= 1'b0;
    #1 cmp(cmd_ok_o, 8'h00);
    for (int i = 0; i < 100 && done !== 1'b1; i++) @(posedge clk_i) #1;
    cmp({7'h00, done}, 8'h01);
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_reg;
    t_div(8'h00, 8'h06);
    t_div(8'h80, 8'h08);
    for (int k = 0; k < 8; k++) begin
      run(8'h40 | (k << 3), 1, 0, expn(0, k == 0 ? 8 : k));
    end
    run(8'h38, 1, 0, expn(0, 0));
    run(8'hc8, 1, 0, expn(1, 1));
    for (int k = 0; k < 4; k++) begin
      run(8'h84 | k, 1, 1, expn(1, k == 0 ? 4 : k));
    end
    run(8'h03, 1, 1, expn(0, 0));
    run(IRT_CFG_RESET, 0, 0, 8'h00);
    t_sub;
    stop_test;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      stop_test;
    end
  end
endmodule
`default_nettype wire
